// [sim/wdg_rstc_model.sv]
// reset controller model: turns an enabled watchdog fault into a reset pulse
// assumes por comes from the bench and loop_en gates the fault loop
`timescale 1ns/10ps
`default_nettype none
module wdg_rstc_model (
    input  wire logic core_clk,
    input  wire logic por,
    input  wire logic loop_en,
    input  wire logic fault_proc_rst,
    input  wire logic fault_sys_rst,
    output logic      rst
);
    logic fault_rst_r; // pending reset taken from the fault lines
    // one cycle of delay, so the pulse ends once the fault drops
    always_ff @(posedge core_clk or posedge por) begin
        if (por) begin
            fault_rst_r <= 1'b0;
        end else begin
            fault_rst_r <= loop_en & (fault_proc_rst | fault_sys_rst);
        end
    end
    assign rst = por | fault_rst_r;
endmodule
`default_nettype wire

// [sim/windowed_watchdog_timer_tb_top.sv]
// self-checking bench for the windowed watchdog top
// assumes slow_en high every cycle, so a tick comes every 128 clocks
`timescale 1ns/10ps
`default_nettype none
module windowed_watchdog_timer_tb_top;
    typedef struct packed {logic w; logic [3:0] a; logic [31:0] d;} wdg_row_s;
    localparam logic [31:0] KEY = {wdg_pkg::KEY_VALUE, 24'h0};
    localparam logic [31:0] M1  = 32'h0FFF_3002; // load 2, irq, reset, all scope
    logic        core_clk   = 1'b0;
    logic        por        = 1'b1;
    logic        loop_en    = 1'b0;
    logic        rst;
    logic [3:0]  reg_addr   = 4'h0;
    logic [31:0] reg_wdata  = 32'h0;
    logic        reg_wr     = 1'b0;
    logic        reg_rd     = 1'b0;
    logic        slow_en    = 1'b1;
    logic        dbg_state  = 1'b0;
    logic        idle_state = 1'b0;
    logic [31:0] reg_rdata, rdata;
    logic        irq, fault, fault_proc_rst, fault_sys_rst;
    int          failures   = 0;
    int          n_compared = 0;
    // plain table: reads with expected data, writes with data
    wdg_row_s rows [9] = '{'{1'b0, wdg_pkg::MODE_OFS, wdg_pkg::MODE_RESET},
        '{1'b0, wdg_pkg::STAT_OFS, 32'h0}, '{1'b0, 4'hC, 32'h0},
        '{1'b1, wdg_pkg::CTRL_OFS, KEY | 32'h1}, '{1'b0, wdg_pkg::STAT_OFS, 32'h0},
        '{1'b1, wdg_pkg::MODE_OFS, M1}, '{1'b0, wdg_pkg::MODE_OFS, M1},
        '{1'b1, wdg_pkg::MODE_OFS, 32'h5}, '{1'b0, wdg_pkg::MODE_OFS, M1}};
    always #10 core_clk = ~core_clk;
    wdg_rstc_model rstc (.core_clk(core_clk), .por(por), .loop_en(loop_en),
        .fault_proc_rst(fault_proc_rst), .fault_sys_rst(fault_sys_rst), .rst(rst));
    wdg_top dut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .slow_en(slow_en), .dbg_state(dbg_state),
        .idle_state(idle_state), .reg_rdata(reg_rdata), .irq(irq), .fault(fault),
        .fault_proc_rst(fault_proc_rst), .fault_sys_rst(fault_sys_rst));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 rdata = reg_rdata;
    endtask
    task automatic do_reset(input logic [31:0] mode);
        @(posedge core_clk);
        por <= 1'b1;
        repeat (20) @(posedge core_clk);
        por <= 1'b0;
        wr(wdg_pkg::MODE_OFS, mode);
    endtask
    // counts clocks until fault rises, bounded by hi
    task automatic wait_fault(input int lo, input int hi);
        int n;
        n = 0;
        while (fault !== 1'b1 && n < hi) begin
            @(posedge core_clk);
            #1 n++;
        end
        check("fault delay", 32'(n >= lo && n < hi), 32'h1);
    endtask
    task automatic results();
        if (failures == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge core_clk);
        failures++;
        results();
    end
    initial begin
        repeat (20) @(posedge core_clk);
        por <= 1'b0;
        // register table: reset values, default window, write once
        for (int i = 0; i < 9; i++) begin
            if (rows[i].w) begin
                wr(rows[i].a, rows[i].d);
            end else begin
                rd(rows[i].a);
                check("table read", rdata, rows[i].d);
            end
        end
        // underflow after three ticks from a keyed restart
        wr(wdg_pkg::CTRL_OFS, KEY | 32'h1);
        wait_fault(378, 392);
        check("irq", irq, 1'b1);
        check("sys rst", {fault_proc_rst, fault_sys_rst}, 2'b11);
        rd(wdg_pkg::STAT_OFS);
        check("status", rdata, 32'h1);
        @(posedge core_clk);
        #1 check("cleared", {irq, fault, fault_proc_rst}, 3'b000);
        // disabled: bad key and bare key ignored, no underflow, restart errs
        do_reset(32'h0000_9001);
        wr(wdg_pkg::CTRL_OFS, 32'h5A00_0001);
        wr(wdg_pkg::CTRL_OFS, KEY);
        repeat (600) @(posedge core_clk);
        rd(wdg_pkg::STAT_OFS);
        check("quiet status", rdata, 32'h0);
        wr(wdg_pkg::CTRL_OFS, KEY | 32'h1);
        #1 check("err fault", {fault, irq, fault_proc_rst}, 3'b110);
        rd(wdg_pkg::STAT_OFS);
        check("err status", rdata, 32'h2);
        // idle then debug halt, then processor-only reset
        do_reset(32'h3FFF_6001);
        wr(wdg_pkg::CTRL_OFS, KEY | 32'h1);
        idle_state <= 1'b1;
        repeat (600) @(posedge core_clk);
        #1 check("idle halt", fault, 1'b0);
        idle_state <= 1'b0;
        dbg_state <= 1'b1;
        repeat (600) @(posedge core_clk);
        #1 check("debug halt", fault, 1'b0);
        dbg_state <= 1'b0;
        wait_fault(0, 300);
        check("proc only", {fault_proc_rst, fault_sys_rst}, 2'b10);
        // restarts every 300 clocks survive only with a cleared prescaler
        do_reset(M1);
        repeat (8) begin
            wr(wdg_pkg::CTRL_OFS, KEY | 32'h1);
            repeat (300) @(posedge core_clk);
        end
        rd(wdg_pkg::STAT_OFS);
        check("kept alive", rdata, 32'h0);
        // fault loops back as a reset and restores the initial state
        loop_en <= 1'b1;
        do_reset(32'h0FFF_2000);
        wait_fault(0, 300);
        repeat (3) @(posedge core_clk);
        rd(wdg_pkg::MODE_OFS);
        check("mode after fault", rdata, wdg_pkg::MODE_RESET);
        rd(wdg_pkg::STAT_OFS);
        check("flags after fault", rdata, 32'h0);
        results();
    end
endmodule
`default_nettype wire

// [src/wdg_counter.sv]
// 12-bit watchdog down counter with reload and underflow pulse
// assumes reload and tick come from the core clock domain
`timescale 1ns/10ps
`default_nettype none
module wdg_counter #(
    parameter int W = wdg_pkg::CNT_W
) (
    input  wire logic         core_clk,
    input  wire logic         rst,
    input  wire logic         reload,
    input  wire logic [W-1:0] load_val,
    input  wire logic         run,
    input  wire logic         tick,
    output logic [W-1:0]      value,
    output logic              underflow
);
    // reload wins; otherwise count down on enabled ticks
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            value     <= '1; // RL3
            underflow <= 1'b0;
        end else begin
            underflow <= 1'b0;
            if (reload) begin // RL5
                value <= load_val;
            end else if (run && tick) begin // RL1
                if (value == '0) begin
                    underflow <= 1'b1;
                    value     <= load_val;
                end else begin
                    value <= value - 1'b1;
                end
            end
        end
    end

    chk_cnt_reload: assert property (@(posedge core_clk) disable iff (rst)
        reload |=> value == $past(load_val)) else $error("reload value lost"); // RL5
    chk_cnt_hold: assert property (@(posedge core_clk) disable iff (rst)
        (!reload && !(run && tick)) |=> $stable(value)) else $error("counter moved while held"); // RL14
endmodule
`default_nettype wire

// [src/wdg_pkg.sv]
// constants shared by the windowed watchdog and its helper modules
// assumes a single core clock domain and a plain register port
// Functional notes
// [RL1] 12-bit down counter loaded from load field
// [RL2] counter ticks on slow clock divided by 128
// [RL3] reset: load FFF, running, fault reset enabled
// [RL4] mode register writable once until processor reset
// [RL5] mode write reloads and restarts counter
// [RL6] keyed restart reloads counter and clears prescaler; a restart raising a window error clears the prescaler but does not reload
// [RL7] control write with wrong key is ignored
// [RL8] underflow sets flag, fault if reset enabled
// [RL9] restart above window delta raises error and fault
// [RL10] delta at or above load disables window check
// [RL11] interrupt when flag set and irq enabled
// [RL12] enabled fault resets block and clears flags
// [RL13] status read clears flags, interrupt and fault
// [RL14] counter halts in debug or idle if enabled
// [RL15] disable bit stops counting and underflow
// [RL16] processor reset restores initial state
// [RL17] fault reset selects whole system or processor
// [RL18] software writes key A5 in bits 31:24
// [RL19] scope bit one: processor only, zero: all
// [RL20] restart needs key and restart bit together
package wdg_pkg;
    // register offsets
    localparam logic [3:0]  CTRL_OFS         = 4'h0;
    localparam logic [3:0]  MODE_OFS         = 4'h4;
    localparam logic [3:0]  STAT_OFS         = 4'h8;
    // control register fields
    localparam int          KEY_LSB          = 24;
    localparam logic [7:0]  KEY_VALUE        = 8'hA5;
    localparam int          RESTART_BIT      = 0;
    // mode register fields
    localparam int          LOAD_LSB         = 0;
    localparam int          IRQ_EN_BIT       = 12;
    localparam int          RST_EN_BIT       = 13;
    localparam int          SCOPE_BIT        = 14;
    localparam int          DIS_BIT          = 15;
    localparam int          DELTA_LSB        = 16;
    localparam int          DBG_HALT_BIT     = 28;
    localparam int          IDLE_HALT_BIT    = 29;
    localparam logic [31:0] MODE_RESET       = 32'h3FFF_2FFF;
    // status register fields
    localparam int          UNF_BIT          = 0;
    localparam int          ERR_BIT          = 1;
    // prescaler ratio and counter width
    localparam int          PRESCALE_DIV     = 128;
    localparam int          CNT_W            = 12;
endpackage

// [src/wdg_prescaler.sv]
// slow clock divide-by-128 prescaler producing one-cycle ticks
// assumes slow_en is a one-cycle slow clock enable in core_clk domain
`timescale 1ns/10ps
`default_nettype none
module wdg_prescaler #(
    parameter int DIV = wdg_pkg::PRESCALE_DIV
) (
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic clear,
    input  wire logic slow_en,
    output logic      tick
);
    localparam int W = $clog2(DIV);
    logic [W-1:0] cnt_r;   // slow periods seen

    // count slow periods, wrap at DIV
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cnt_r <= '0;
            tick  <= 1'b0;
        end else if (clear) begin // RL6
            cnt_r <= '0;
            tick  <= 1'b0;
        end else begin
            tick <= 1'b0;
            if (slow_en) begin
                if (cnt_r == W'(DIV - 1)) begin // RL2
                    cnt_r <= '0;
                    tick  <= 1'b1;
                end else begin
                    cnt_r <= cnt_r + 1'b1;
                end
            end
        end
    end

    chk_tick_spacing: assert property (@(posedge core_clk) disable iff (rst)
        tick |=> !tick) else $error("prescaler ticks back to back"); // RL2
endmodule
`default_nettype wire

// [src/wdg_top.sv]
// windowed watchdog: register port, window check, flags and fault
// assumes software strobes are one cycle and never overlap
//
// Implementation choices: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module wdg_top (
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic        slow_en,
    input  wire logic        dbg_state,
    input  wire logic        idle_state,
    output logic [31:0]      reg_rdata,
    output logic             irq,
    output logic             fault,
    output logic             fault_proc_rst,
    output logic             fault_sys_rst
);
    logic [31:0]       mode_r;        // mode register image
    logic              mode_locked_r; // set after first mode write
    logic              unf_r;         // underflow flag
    logic              err_r;         // window error flag
    logic [11:0]       cnt_val;       // counter value
    logic              cnt_unf;       // counter underflow pulse
    logic              tick;          // prescaler tick
    logic              key_ok;        // control write carries key
    logic              restart;       // accepted restart command
    logic              mode_wr;       // accepted mode write
    logic              win_err;       // restart outside window
    logic              stat_rd;       // status register read
    logic              run;           // counter allowed to move
    logic              unf_ev;        // counted underflow
    logic [11:0]       load_val;
    logic [11:0]       delta_val;

    assign load_val  = mode_r[wdg_pkg::LOAD_LSB +: 12];   // RL1
    assign delta_val = mode_r[wdg_pkg::DELTA_LSB +: 12];
    assign key_ok  = reg_wr && reg_addr == wdg_pkg::CTRL_OFS
                     && reg_wdata[wdg_pkg::KEY_LSB +: 8] == wdg_pkg::KEY_VALUE; // RL7 RL18
    assign restart = key_ok && reg_wdata[wdg_pkg::RESTART_BIT]; // RL20
    assign mode_wr = reg_wr && reg_addr == wdg_pkg::MODE_OFS && !mode_locked_r; // RL4
    // window check applies even when disabled; delta >= load never errs
    assign win_err = restart && (cnt_val > delta_val) && (delta_val < load_val); // RL9 RL10
    assign stat_rd = reg_rd && reg_addr == wdg_pkg::STAT_OFS;
    assign run = !mode_r[wdg_pkg::DIS_BIT] // RL15
                 && !(dbg_state && mode_r[wdg_pkg::DBG_HALT_BIT]) // RL14
                 && !(idle_state && mode_r[wdg_pkg::IDLE_HALT_BIT]);
    assign unf_ev = cnt_unf && !mode_r[wdg_pkg::DIS_BIT]; // RL15

    // prescaler cleared by accepted restart and by mode write
    wdg_prescaler #(.DIV(wdg_pkg::PRESCALE_DIV)) u_pre (
        .core_clk (core_clk),
        .rst      (rst),
        .clear    (restart || mode_wr), // RL6
        .slow_en  (slow_en),
        .tick     (tick)
    );

    // down counter; a faulted restart does not reload
    wdg_counter #(.W(wdg_pkg::CNT_W)) u_cnt (
        .core_clk  (core_clk),
        .rst       (rst),
        .reload    ((restart && !win_err) || mode_wr), // RL5 RL6
        .load_val  (mode_wr ? reg_wdata[wdg_pkg::LOAD_LSB +: 12] : load_val),
        .run       (run),
        .tick      (tick),
        .value     (cnt_val),
        .underflow (cnt_unf)
    );

    // write-once mode register, only reset restores it
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            mode_r        <= wdg_pkg::MODE_RESET; // RL3 RL16
            mode_locked_r <= 1'b0;
        end else if (mode_wr) begin // RL4
            mode_r        <= reg_wdata;
            mode_locked_r <= 1'b1;
        end
    end

    // sticky flags; a new event wins over the read clear
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            unf_r <= 1'b0; // RL12
            err_r <= 1'b0;
        end else begin
            if (unf_ev) begin // RL8
                unf_r <= 1'b1;
            end else if (stat_rd) begin // RL13
                unf_r <= 1'b0;
            end
            if (win_err) begin // RL9
                err_r <= 1'b1;
            end else if (stat_rd) begin
                err_r <= 1'b0;
            end
        end
    end

    // fault, reset requests and interrupt outputs
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            fault          <= 1'b0;
            fault_proc_rst <= 1'b0;
            fault_sys_rst  <= 1'b0;
            irq            <= 1'b0;
        end else begin
            if ((unf_ev && mode_r[wdg_pkg::RST_EN_BIT]) || win_err) begin // RL8 RL9
                fault <= 1'b1;
            end else if (stat_rd) begin // RL13
                fault <= 1'b0;
            end
            // reset scope select on enabled faults
            if ((unf_ev || win_err) && mode_r[wdg_pkg::RST_EN_BIT]) begin // RL12 RL17
                fault_proc_rst <= 1'b1;
                fault_sys_rst  <= !mode_r[wdg_pkg::SCOPE_BIT]; // RL19
            end else if (stat_rd) begin
                fault_proc_rst <= 1'b0;
                fault_sys_rst  <= 1'b0;
            end
            if ((unf_ev || win_err) && mode_r[wdg_pkg::IRQ_EN_BIT]) begin // RL11
                irq <= 1'b1;
            end else if (stat_rd) begin
                irq <= 1'b0;
            end else begin
                irq <= (unf_r || err_r) && mode_r[wdg_pkg::IRQ_EN_BIT];
            end
        end
    end

    // read data one cycle after read strobe, zero otherwise
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd && reg_addr == wdg_pkg::MODE_OFS) begin
            reg_rdata <= mode_r;
        end else if (stat_rd) begin
            reg_rdata <= {30'h0000_0000, err_r, unf_r};
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

    chk_bad_key: assert property (@(posedge core_clk) disable iff (rst)
        (reg_wr && reg_addr == wdg_pkg::CTRL_OFS
         && reg_wdata[31:24] != 8'hA5) |=> !$rose(err_r)) else $error("unkeyed write had effect"); // RL7
    chk_mode_once: assert property (@(posedge core_clk) disable iff (rst)
        (mode_locked_r && reg_wr) |=> $stable(mode_r)) else $error("mode rewritten"); // RL4
    chk_win_err: assert property (@(posedge core_clk) disable iff (rst)
        win_err |=> err_r && fault) else $error("window error not flagged"); // RL9
    chk_unf_flag: assert property (@(posedge core_clk) disable iff (rst)
        unf_ev |=> unf_r) else $error("underflow not flagged"); // RL8
    chk_read_clear: assert property (@(posedge core_clk) disable iff (rst)
        (stat_rd && !unf_ev && !win_err) |=> !unf_r && !err_r && !fault && !irq)
        else $error("status read did not clear"); // RL13
    chk_irq_cause: assert property (@(posedge core_clk) disable iff (rst)
        irq |-> mode_r[wdg_pkg::IRQ_EN_BIT]) else $error("irq without enable"); // RL11
    chk_scope_sel: assert property (@(posedge core_clk) disable iff (rst)
        fault_sys_rst |-> fault_proc_rst) else $error("system reset without processor"); // RL19
    chk_disabled: assert property (@(posedge core_clk) disable iff (rst)
        mode_r[wdg_pkg::DIS_BIT] |-> !unf_ev) else $error("underflow while disabled"); // RL15
endmodule
`default_nettype wire
